// ===== logic/mnre_core.sv
// execution core for multiply, negate, no-operation and return from interrupt
`timescale 1ns/1ps
module mnre_core
  import mnre_pkg::*;
#(
  parameter int STACK_AW = 4
) (
  input wire logic clk, // 20 MHz system clock
  input wire logic rst, // synchronous reset, active high
  input wire logic [7:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // byte lanes
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest // stall
);
  import mnre_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    mnre_state_type st;
    logic second;
    mnre_kind_type kind;
    logic [15:0] op;
    logic [7:0] working_register;
    logic [7:0] product_low;
    logic [7:0] product_high;
    logic [3:0] alusta;
    logic [7:0] cpu_status_register;
    logic [15:0] pc;
    logic [7:0] pc_high_latch;
    logic [STACK_AW-1:0] sp;
    logic [7:0] faddr;
    logic waitreq;
    logic [1:0] bcnt;
    logic [31:0] rdata;
  } mnre_regs_type;

  mnre_regs_type s_r;
  mnre_regs_type s_nxt;

  if (STACK_AW < 1 || STACK_AW > 8) begin : g_chk
    $error("mnre_core: STACK_AW out of range");
  end

  mnre_mem_if #(.AW(8), .DW(8)) fm ();
  mnre_mem_if #(.AW(STACK_AW), .DW(16)) sm ();

  logic [15:0] alu_prod;
  logic [7:0] alu_neg;
  logic [3:0] alu_flags;
  logic busy;
  logic acc_wr;
  logic exec_fwe;

  function automatic logic [7:0] merge8(logic [7:0] old, logic [31:0] d, logic [3:0] be);
    return be[0] ? d[7:0] : old;
  endfunction

  function automatic logic [15:0] merge16(logic [15:0] old, logic [31:0] d, logic [3:0] be);
    return {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
  endfunction

  // ==========================================================
  // datapath and memories
  mnre_alu u_alu (
    .w_in(s_r.working_register),
    .f_in(fm.rdata),
    .prod(alu_prod),
    .neg(alu_neg),
    .flags(alu_flags)
  );

  mnre_mem #(.AW(8), .DW(8)) u_file (
    .clk(clk),
    .rst(rst),
    .port(fm.mem)
  );

  mnre_mem #(.AW(STACK_AW), .DW(16)) u_stack (
    .clk(clk),
    .rst(rst),
    .port(sm.mem)
  );

  assign busy = (s_r.st != ST_IDLE);
  assign acc_wr = avs_write & ~s_r.waitreq;
  // operand read in Q2, held through Q4 since the address is the latched opcode
  assign exec_fwe = (s_r.st == ST_Q4) && (s_r.kind == OPK_NEG);

  assign fm.raddr = busy ? s_r.op[7:0] : s_r.faddr;
  assign fm.waddr = busy ? s_r.op[7:0] : s_r.faddr;
  assign fm.wdata = busy ? alu_neg : avs_writedata[7:0];
  assign fm.we = exec_fwe | (acc_wr && avs_address == REG_FDATA && avs_byteenable[0]);

  // stack top is always presented, so the pop in Q4 needs no extra read cycle
  assign sm.raddr = STACK_AW'(s_r.sp - 1'b1);
  assign sm.waddr = s_r.sp;
  assign sm.wdata = avs_writedata[15:0];
  assign sm.we = acc_wr && avs_address == REG_STACK;

  // ==========================================================
  // next state
  always_comb begin
    logic [31:0] rd;
    rd = '0;
    s_nxt = s_r;
    case (avs_address)
      REG_INSTR: rd = {16'h0000, s_r.op};
      REG_WORKING_REGISTER: rd = {24'h000000, s_r.working_register};
      REG_PRODUCT_LOW: rd = {24'h000000, s_r.product_low};
      REG_PRODUCT_HIGH: rd = {24'h000000, s_r.product_high};
      REG_ALUSTA: rd = {28'h0000000, s_r.alusta};
      REG_CPU_STATUS_REGISTER: rd = {24'h000000, s_r.cpu_status_register};
      REG_PC: rd = {16'h0000, s_r.pc};
      REG_PC_HIGH_LATCH: rd = {24'h000000, s_r.pc_high_latch};
      REG_STACK: rd = {16'h0000, sm.rdata};
      REG_FADDR: rd = {24'h000000, s_r.faddr};
      REG_FDATA: rd = {24'h000000, fm.rdata};
      default: rd = '0;
    endcase

    // bus: every access waits while an instruction runs
    if ((avs_read | avs_write) && s_r.waitreq) begin
      if (!busy) begin
        if (s_r.bcnt == BUS_WAIT) begin
          s_nxt.waitreq = 1'b0;
          s_nxt.bcnt = 2'h0;
          s_nxt.rdata = rd;
        end else begin
          s_nxt.bcnt = 2'(s_r.bcnt + 2'h1);
        end
      end
    end else begin
      s_nxt.waitreq = 1'b1;
      s_nxt.bcnt = 2'h0;
    end

    if (acc_wr) begin
      case (avs_address)
        REG_INSTR: begin
          s_nxt.op = merge16(s_r.op, avs_writedata, avs_byteenable);
          s_nxt.st = ST_Q1;
          s_nxt.second = 1'b0;
        end
        REG_WORKING_REGISTER: s_nxt.working_register = merge8(s_r.working_register, avs_writedata, avs_byteenable);
        REG_PRODUCT_LOW: s_nxt.product_low = merge8(s_r.product_low, avs_writedata, avs_byteenable);
        REG_PRODUCT_HIGH: s_nxt.product_high = merge8(s_r.product_high, avs_writedata, avs_byteenable);
        REG_ALUSTA: s_nxt.alusta = avs_byteenable[0] ? avs_writedata[3:0] : s_r.alusta;
        REG_CPU_STATUS_REGISTER: s_nxt.cpu_status_register = merge8(s_r.cpu_status_register, avs_writedata, avs_byteenable);
        REG_PC: s_nxt.pc = merge16(s_r.pc, avs_writedata, avs_byteenable);
        REG_PC_HIGH_LATCH: s_nxt.pc_high_latch = merge8(s_r.pc_high_latch, avs_writedata, avs_byteenable);
        REG_STACK: s_nxt.sp = STACK_AW'(s_r.sp + 1'b1);
        REG_FADDR: s_nxt.faddr = merge8(s_r.faddr, avs_writedata, avs_byteenable);
        default: ;
      endcase
    end

    // execution, one Q phase per clock
    case (s_r.st)
      ST_IDLE: ;
      ST_Q1: begin
        // the second cycle of a return decodes as nothing
        s_nxt.kind = s_r.second ? OPK_NOP : mnre_decode(s_r.op);
        s_nxt.st = ST_Q2;
      end
      ST_Q2: s_nxt.st = ST_Q3;
      ST_Q3: begin
        if (s_r.kind == OPK_RETI) begin
          s_nxt.cpu_status_register[GIE_BIT] = 1'b0;
        end
        s_nxt.st = ST_Q4;
      end
      ST_Q4: begin
        case (s_r.kind)
          OPK_MUL: begin
            s_nxt.product_high = alu_prod[15:8];
            s_nxt.product_low = alu_prod[7:0];
          end
          OPK_NEG: begin
            if (!s_r.op[NEG_SEL_BIT]) begin
              s_nxt.working_register = alu_neg;
            end
            s_nxt.alusta = alu_flags;
          end
          OPK_RETI: begin
            s_nxt.pc = sm.rdata;
            s_nxt.sp = STACK_AW'(s_r.sp - 1'b1);
          end
          default: ;
        endcase
        if (s_r.kind == OPK_RETI && !s_r.second) begin
          s_nxt.second = 1'b1;
          s_nxt.st = ST_Q1;
        end else begin
          s_nxt.st = ST_IDLE;
        end
      end
      default: s_nxt.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '{st: ST_IDLE, second: 1'b0, kind: OPK_NOP, op: WORD_RST, working_register: BYTE_RST,
               product_low: BYTE_RST, product_high: BYTE_RST, alusta: ALUSTA_RST, cpu_status_register: CPU_STATUS_REGISTER_RST,
               pc: WORD_RST, pc_high_latch: BYTE_RST, sp: '0, faddr: BYTE_RST, waitreq: 1'b1,
               bcnt: 2'h0, rdata: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign avs_readdata = s_r.rdata;
  assign avs_waitrequest = s_r.waitreq;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic q4_mul;
  logic q4_neg;
  logic q4_ret1;
  assign q4_mul = (s_r.st == ST_Q4) && (s_r.kind == OPK_MUL);
  assign q4_neg = (s_r.st == ST_Q4) && (s_r.kind == OPK_NEG);
  assign q4_ret1 = (s_r.st == ST_Q4) && (s_r.kind == OPK_RETI) && !s_r.second;

  a_mul_product: assert property (q4_mul |=>
    {s_r.product_high, s_r.product_low} == 16'($past(s_r.working_register) * $past(fm.rdata)))
    else $error("multiply product wrong");

  a_mul_high_byte: assert property (
    (s_r.st == ST_Q1 && s_r.op[15:8] == OP_MUL_HI && !s_r.second) ##3 1'b1 |=>
    s_r.product_high == 8'($past({8'h00, s_r.working_register} * {8'h00, fm.rdata}) >> 8))
    else $error("product high byte wrong");

  a_mul_keeps_state: assert property (q4_mul |-> !fm.we ##1
    ($stable(s_r.working_register) && $stable(s_r.alusta) && $stable(s_r.cpu_status_register)))
    else $error("multiply changed working, file or flags");

  a_mul_zero_flag: assert property ((q4_mul && alu_prod == 16'h0000) |=>
    s_r.alusta[FL_Z] == $past(s_r.alusta[FL_Z]))
    else $error("multiply touched the zero flag");

  a_neg_value: assert property (q4_neg |->
    fm.we && fm.wdata == 8'(~s_r.working_register + 8'h01) && fm.waddr == s_r.op[7:0])
    else $error("negate result or target wrong");

  a_neg_select: assert property (q4_neg |=>
    ($past(s_r.op[NEG_SEL_BIT]) ? $stable(s_r.working_register) : s_r.working_register == $past(fm.wdata)))
    else $error("negate destination select wrong");

  a_neg_flags: assert property (q4_neg |=>
    s_r.alusta[FL_Z] == ($past(s_r.working_register) == 8'h00) && s_r.alusta[FL_C] == ($past(s_r.working_register) == 8'h00)
    && s_r.alusta[FL_OV] == ($past(s_r.working_register) == 8'h80)
    && s_r.alusta[FL_DC] == ($past(s_r.working_register[3:0]) == 4'h0))
    else $error("negate flags wrong");

  a_ret_pop_pc: assert property (q4_ret1 |=>
    s_r.pc == $past(sm.rdata) && $stable(s_r.pc_high_latch) && s_r.sp == STACK_AW'($past(s_r.sp) - 1'b1))
    else $error("return did not pop into pc");

  a_ret_clear_gie: assert property (
    (s_r.st == ST_Q3 && s_r.kind == OPK_RETI) |=>
    !s_r.cpu_status_register[GIE_BIT] && s_r.cpu_status_register[3:0] == $past(s_r.cpu_status_register[3:0])
    && s_r.cpu_status_register[7:5] == $past(s_r.cpu_status_register[7:5]) && $stable(s_r.alusta))
    else $error("return changed status wrongly");

  a_nop_quiet: assert property (
    (s_r.st == ST_Q1 && s_r.op == OP_NOP) |=>
    (!fm.we && $stable(s_r.working_register) && $stable(s_r.alusta) && $stable(s_r.pc)
     && $stable({s_r.product_high, s_r.product_low}))[*3] ##1 s_r.st == ST_IDLE)
    else $error("no operation changed state or took too long");

  a_ret_two_cycles: assert property (
    (s_r.st == ST_Q1 && s_r.op == OP_RETI && !s_r.second) |->
    ##2 (s_r.st == ST_Q3) ##1 q4_ret1 ##4 (s_r.st == ST_Q4 && s_r.second) ##1 s_r.st == ST_IDLE)
    else $error("return length or phase order wrong");

  a_ret_idle_second: assert property ((s_r.second && s_r.st != ST_IDLE) |->
    s_r.st == ST_Q1 || s_r.kind == OPK_NOP)
    else $error("second return cycle did work");

  c_mul_zero: cover property (q4_mul && alu_prod == 16'h0000);
  c_neg_file_only: cover property (q4_neg && s_r.op[NEG_SEL_BIT]);
  c_ret_done: cover property (s_r.second && s_r.st == ST_Q4 ##1 s_r.st == ST_IDLE);
endmodule

// ===== logic/mnre_pkg.sv
// shared constants, types and decode for the multiply/negate/return execution block
package mnre_pkg;

  // ==========================================================
  // opcode patterns
  localparam logic [7:0] OP_MUL_HI = 8'h34;
  localparam logic [6:0] OP_NEG_HI = 7'h16;
  localparam logic [15:0] OP_NOP = 16'h0000;
  localparam logic [15:0] OP_RETI = 16'h0005;
  localparam int NEG_SEL_BIT = 8;

  // ==========================================================
  // status bit positions
  localparam int FL_C = 0;
  localparam int FL_DC = 1;
  localparam int FL_Z = 2;
  localparam int FL_OV = 3;
  localparam int GIE_BIT = 4;

  // ==========================================================
  // register byte offsets on the avalon slave
  localparam logic [7:0] REG_INSTR = 8'h00;
  localparam logic [7:0] REG_WORKING_REGISTER = 8'h04;
  localparam logic [7:0] REG_PRODUCT_LOW = 8'h08;
  localparam logic [7:0] REG_PRODUCT_HIGH = 8'h0c;
  localparam logic [7:0] REG_ALUSTA = 8'h10;
  localparam logic [7:0] REG_CPU_STATUS_REGISTER = 8'h14;
  localparam logic [7:0] REG_PC = 8'h18;
  localparam logic [7:0] REG_PC_HIGH_LATCH = 8'h1c;
  localparam logic [7:0] REG_STACK = 8'h20;
  localparam logic [7:0] REG_FADDR = 8'h24;
  localparam logic [7:0] REG_FDATA = 8'h28;

  // ==========================================================
  // reset values and timing
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [3:0] ALUSTA_RST = 4'h0;
  localparam logic [7:0] CPU_STATUS_REGISTER_RST = 8'h10;
  localparam logic [1:0] BUS_WAIT = 2'h1;
  localparam int Q_PHASES = 4;

  // ==========================================================
  // states and instruction kinds
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_Q1 = 3'b001,
    ST_Q2 = 3'b011,
    ST_Q3 = 3'b010,
    ST_Q4 = 3'b110
  } mnre_state_type;

  typedef enum logic [1:0] {
    OPK_NOP = 2'h0,
    OPK_MUL = 2'h1,
    OPK_NEG = 2'h2,
    OPK_RETI = 2'h3
  } mnre_kind_type;

  // unknown opcodes fall back to no operation
  function automatic mnre_kind_type mnre_decode(logic [15:0] op);
    mnre_kind_type k;
    k = OPK_NOP;
    if (op[15:8] == OP_MUL_HI) begin
      k = OPK_MUL;
    end else if (op[15:9] == OP_NEG_HI) begin
      k = OPK_NEG;
    end else if (op == OP_RETI) begin
      k = OPK_RETI;
    end
    return k;
  endfunction

endpackage

// ===== logic/mnre_mem_if.sv
// port bundle between the core and a small two-port memory
`timescale 1ns/1ps
interface mnre_mem_if #(
  parameter int AW = 8,
  parameter int DW = 8
) ();
  logic [AW-1:0] raddr;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  logic we;
  modport ctrl (output raddr, output waddr, output wdata, output we, input rdata);
  modport mem (input raddr, input waddr, input wdata, input we, output rdata);
endinterface

// ===== logic/mnre_mem.sv
// two-port memory with registered read data
`timescale 1ns/1ps
module mnre_mem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset, active high
  mnre_mem_if.mem port // memory access bundle
);
  logic [DW-1:0] mem_r [2**AW];
  logic [DW-1:0] rdata_r;

  if (AW < 1 || AW > 12 || DW < 1) begin : g_chk
    $error("mnre_mem: unsupported geometry");
  end

  // write-before-read is not forwarded: a read of the same word sees old data
  always_ff @(posedge clk) begin
    if (port.we) begin
      mem_r[port.waddr] <= port.wdata;
    end
    if (rst) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= mem_r[port.raddr];
    end
  end

  assign port.rdata = rdata_r;
endmodule

// ===== logic/mnre_alu.sv
// multiplier and negator datapath
`timescale 1ns/1ps
module mnre_alu
  import mnre_pkg::*;
(
  input wire logic [7:0] w_in, // working register value
  input wire logic [7:0] f_in, // file register value
  output logic [15:0] prod, // unsigned product
  output logic [7:0] neg, // two's complement of w_in
  output logic [3:0] flags // flags of the negate
);
  logic [8:0] sum;
  logic [4:0] low;

  always_comb begin
    prod = 16'(w_in * f_in);
    sum = {1'b0, ~w_in} + 9'h001;
    low = {1'b0, ~w_in[3:0]} + 5'h01;
    neg = sum[7:0];
    flags = '0;
    flags[FL_C] = sum[8];
    flags[FL_DC] = low[4];
    flags[FL_Z] = (sum[7:0] == 8'h00);
    flags[FL_OV] = (w_in == 8'h80);
  end
endmodule

// ===== tb/multiply_negate_return_exec_bench.sv
// self-checking bench for the multiply, negate, no-operation and return core
`timescale 1ns/1ps
module multiply_negate_return_exec_bench;
  import mnre_pkg::*;
  logic clk;
  logic rst;
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  int err_count;
  int num_checks;
  logic [7:0] rst_adr [10] = '{REG_INSTR, REG_WORKING_REGISTER, REG_PRODUCT_LOW, REG_PRODUCT_HIGH, REG_ALUSTA, REG_CPU_STATUS_REGISTER, REG_PC,
    REG_PC_HIGH_LATCH, REG_FADDR, 8'h2c};
  logic [31:0] rst_val [10] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h10, 32'h0, 32'h0, 32'h0, 32'h0};

  mnre_core #(.STACK_AW(4)) i_mnre_core (
    .clk(clk),
    .rst(rst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ==========================================================
  // checking and bus tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // called just after a rising edge; waitrequest and read data are taken at the accepting edge
  // one idle edge after release, so a following call never re-drives a strobe in the same step
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
      output int n);
    n = 0;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    q = avs_readdata;
    if (n >= 40) begin
      err_count++;
      $display("ERROR waitrequest expected 0 seen stuck at %h", a);
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    int n;
    bus(1'b1, a, d, q, n);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    int n;
    bus(1'b0, a, 32'h0, q, n);
  endtask

  task automatic setf(input logic [7:0] f, input logic [7:0] v);
    wr(REG_FADDR, {24'h0, f});
    wr(REG_FDATA, {24'h0, v});
  endtask

  task automatic getf(input logic [7:0] f, output logic [31:0] q);
    wr(REG_FADDR, {24'h0, f});
    rd(REG_FDATA, q);
  endtask

  // the access right after an opcode stalls for its run time plus two
  task automatic exec(input logic [15:0] op, input int cyc);
    logic [31:0] q;
    int n;
    wr(REG_INSTR, {16'h0, op});
    bus(1'b0, REG_INSTR, 32'h0, q, n);
    chk("instr", q, {16'h0, op});
    chk("busy span", n, cyc + 2);
  endtask

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask

  // ==========================================================
  // expectations
  function automatic logic [3:0] neg_flags(input logic [7:0] w);
    logic [3:0] fl;
    logic [7:0] r;
    r = ~w + 8'h01;
    fl = 4'h0;
    fl[FL_C] = (w == 8'h00);
    fl[FL_DC] = (w[3:0] == 4'h0);
    fl[FL_Z] = (r == 8'h00);
    fl[FL_OV] = (w == 8'h80);
    return fl;
  endfunction

  task automatic mul_case(input logic [7:0] w, input logic [7:0] f, input logic [7:0] fv, input logic [3:0] al);
    logic [31:0] q;
    logic [15:0] p;
    p = {8'h0, w} * {8'h0, fv};
    wr(REG_WORKING_REGISTER, {24'h0, w});
    setf(f, fv);
    wr(REG_ALUSTA, {28'h0, al});
    exec({OP_MUL_HI, f}, 4);
    rd(REG_PRODUCT_HIGH, q);
    chk("product high", q, {24'h0, p[15:8]});
    rd(REG_PRODUCT_LOW, q);
    chk("product low", q, {24'h0, p[7:0]});
    rd(REG_WORKING_REGISTER, q);
    chk("mul working", q, {24'h0, w});
    getf(f, q);
    chk("mul file", q, {24'h0, fv});
    rd(REG_ALUSTA, q);
    chk("mul flags", q, {28'h0, al});
  endtask

  task automatic neg_case(input logic [7:0] w, input logic [7:0] f, input logic s, input logic [7:0] fold);
    logic [31:0] q;
    logic [7:0] r;
    r = ~w + 8'h01;
    wr(REG_WORKING_REGISTER, {24'h0, w});
    setf(f, fold);
    wr(REG_ALUSTA, {28'h0, ~neg_flags(w)});
    exec({OP_NEG_HI, s, f}, 4);
    getf(f, q);
    chk("neg file", q, {24'h0, r});
    rd(REG_WORKING_REGISTER, q);
    chk("neg working", q, {24'h0, (s ? w : r)});
    rd(REG_ALUSTA, q);
    chk("neg flags", q, {28'h0, neg_flags(w)});
  endtask

  // ==========================================================
  // closing and watchdog
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #3000000;
    err_count++;
    $display("ERROR watchdog expected finish seen hang");
    close_out();
  end

  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] q;
    logic [15:0] a;
    logic [15:0] b;
    rst = 1'b1;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    err_count = 0;
    num_checks = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    void'($urandom(18));
    for (int i = 0; i < 10; i++) begin
      rd(rst_adr[i], q);
      chk("reset value", q, rst_val[i]);
    end
    end_test("reset");
    mul_case(8'hc4, 8'h20, 8'hb5, 4'h0);
    mul_case(8'h00, 8'h21, 8'h9c, 4'h0);
    mul_case(8'hff, 8'h22, 8'hff, 4'hf);
    for (int i = 0; i < 6; i++) begin
      mul_case(8'($urandom), 8'($urandom), 8'($urandom), 4'($urandom));
    end
    end_test("multiply");
    for (int i = 0; i < 8; i++) begin
      neg_case(i[2:1] == 2'h0 ? 8'h00 : (i[2:1] == 2'h1 ? 8'h80 : (i[2:1] == 2'h2 ? 8'h3a : 8'h01)),
        8'h30, i[0], 8'hab);
    end
    for (int i = 0; i < 6; i++) begin
      neg_case(8'($urandom), 8'($urandom), 1'($urandom), 8'($urandom));
    end
    end_test("negate");
    wr(REG_WORKING_REGISTER, 32'h5a);
    wr(REG_ALUSTA, 32'ha);
    wr(REG_CPU_STATUS_REGISTER, 32'h3c);
    wr(REG_PC, 32'h1234);
    setf(8'h40, 8'h77);
    exec(OP_NOP, 4);
    rd(REG_WORKING_REGISTER, q);
    chk("nop working", q, 32'h5a);
    rd(REG_ALUSTA, q);
    chk("nop flags", q, 32'ha);
    rd(REG_CPU_STATUS_REGISTER, q);
    chk("nop status", q, 32'h3c);
    rd(REG_PC, q);
    chk("nop pc", q, 32'h1234);
    getf(8'h40, q);
    chk("nop file", q, 32'h77);
    end_test("no operation");
    a = 16'($urandom);
    b = 16'($urandom);
    wr(REG_ALUSTA, 32'h5);
    wr(REG_PC_HIGH_LATCH, 32'h7e);
    wr(REG_CPU_STATUS_REGISTER, 32'hff);
    wr(REG_STACK, {16'h0, a});
    wr(REG_STACK, {16'h0, b});
    exec(OP_RETI, 8);
    rd(REG_PC, q);
    chk("return pc", q, {16'h0, b});
    rd(REG_PC_HIGH_LATCH, q);
    chk("return latch", q, 32'h7e);
    rd(REG_CPU_STATUS_REGISTER, q);
    chk("return status", q, 32'hef);
    rd(REG_ALUSTA, q);
    chk("return flags", q, 32'h5);
    wr(REG_CPU_STATUS_REGISTER, 32'h10);
    exec(OP_RETI, 8);
    rd(REG_PC, q);
    chk("second pop pc", q, {16'h0, a});
    rd(REG_CPU_STATUS_REGISTER, q);
    chk("second status", q, 32'h0);
    end_test("return");
    close_out();
  end
endmodule
